// ---- dv/dmcc_ctrl_monitor.sv ----
// Port checker of the cache controller.
// Bound into dmcc_ctrl from the bench top file.
`timescale 1ns/1ps
module dmcc_ctrl_monitor (
   input wire clk,
   input wire resetn,
   input wire cpu_req,
   input wire [31:0] cpu_addr,
   input wire cpu_ready_reg,
   input wire cpu_hit_reg,
   input wire mem_req_reg,
   input wire [31:0] mem_addr_reg,
   input wire mem_ack
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // Memory answer and its region
   wire ack = mem_ack && mem_req_reg;
   wire cached = mem_addr_reg[31:24] == 8'h00;
   property p_look;
      $rose(cpu_req) |-> ##2 cpu_ready_reg && cpu_hit_reg || mem_req_reg;
   endproperty
   a_look: assert property (p_look) else $error("no lookup");
   property p_nomem;
      cpu_ready_reg && cpu_hit_reg |->
         !$past(mem_req_reg) && !$past(mem_req_reg, 2);
   endproperty
   a_nomem: assert property (p_nomem) else $error("hit used mem");
   property p_addr;
      $rose(mem_req_reg) |-> mem_addr_reg == {cpu_addr[31:2], 2'b00};
   endproperty
   a_addr: assert property (p_addr) else $error("bad fetch addr");
   property p_hold;
      mem_req_reg && !mem_ack |=> mem_req_reg && $stable(mem_addr_reg);
   endproperty
   a_hold: assert property (p_hold) else $error("req dropped");
   property p_drop; ack |=> !mem_req_reg; endproperty
   a_drop: assert property (p_drop) else $error("req stuck");
   property p_fill;
      ack && cached |-> !cpu_ready_reg[*2] ##1 cpu_ready_reg && !cpu_hit_reg;
   endproperty
   a_fill: assert property (p_fill) else $error("fill timing");
   property p_byp; ack && !cached |=> cpu_ready_reg && !cpu_hit_reg;
   endproperty
   a_byp: assert property (p_byp) else $error("bypass timing");
   property p_rdy; cpu_ready_reg |=> !cpu_ready_reg; endproperty
   a_rdy: assert property (p_rdy) else $error("ready wide");
endmodule

// ---- dv/dmcc_ctrl_tb_top.sv ----
// Self-checking bench of the cache controller with a memory model.
// Needs the design, dmcc_mem_model and dmcc_ctrl_monitor compiled first.
`timescale 1ns/1ps
module dmcc_ctrl_tb_top;
   logic clk, resetn, cpu_req, cpu_ready_reg, cpu_hit_reg;
   logic mem_req_reg, mem_ack;
   logic [31:0] cpu_addr, cpu_rdata_reg, mem_addr_reg, mem_rdata, a;
   logic [3:0] cpu_be;
   logic [2:0] lat;
   logic [7:0] shadow [int];
   int mismatches = 0;
   int n_compared = 0;
   int cyc = 0;
   dmcc_ctrl u_dmcc_ctrl (
      .clk(clk),
      .resetn(resetn),
      .cpu_req(cpu_req),
      .cpu_addr(cpu_addr),
      .cpu_be(cpu_be),
      .cpu_ready_reg(cpu_ready_reg),
      .cpu_rdata_reg(cpu_rdata_reg),
      .cpu_hit_reg(cpu_hit_reg),
      .mem_req_reg(mem_req_reg),
      .mem_addr_reg(mem_addr_reg),
      .mem_ack(mem_ack),
      .mem_rdata(mem_rdata)
   );
   dmcc_mem_model u_dmcc_mem_model (
      .clk(clk),
      .mem_req_reg(mem_req_reg),
      .mem_addr_reg(mem_addr_reg),
      .lat(lat),
      .mem_ack(mem_ack),
      .mem_rdata(mem_rdata)
   );
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         tally_and_finish();
      end
   end
   task automatic chk_w(string n, logic [31:0] e, logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic chk_b(string n, logic e, logic g);
      chk_w(n, {31'h0, e}, {31'h0, g});
   endtask
   task automatic do_reset();
      resetn = 1'b0;
      repeat (8) @(negedge clk);
      resetn = 1'b1;
      shadow.delete();
   endtask
   // One processor read; expectation from the shadow tag table
   task automatic acc(logic [31:0] ad, logic [3:0] be);
      logic hit;
      logic [31:0] m;
      int n;
      hit = ad[31:24] == 8'h00 && shadow.exists(ad[15:2]);
      hit = hit && shadow[ad[15:2]] == ad[23:16];
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      @(negedge clk);
      lat = 3'($urandom_range(7));
      cpu_req = 1'b1;
      cpu_addr = ad;
      cpu_be = be;
      n = 0;
      while (cpu_ready_reg !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      cpu_req = 1'b0;
      m = ({ad[31:2], 2'b00} ^ 32'h3c5aa5c3) & m;
      chk_b("ready", 1'b1, cpu_ready_reg);
      chk_b("hit", hit, cpu_hit_reg);
      chk_w("data", m, cpu_rdata_reg);
      // Cycles from the request edge to the ready pulse
      if (hit)
         chk_w("hit_lat", 32'h2, 32'(n));
      else if (ad[31:24] == 8'h00)
         chk_w("fill_lat", 32'(lat) + 32'h4, 32'(n));
      else
         chk_w("bypass_lat", 32'(lat) + 32'h3, 32'(n));
      if (ad[31:24] == 8'h00)
         shadow[ad[15:2]] = ad[23:16];
   endtask
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      cpu_req = 1'b0;
      cpu_addr = 32'h0;
      cpu_be = 4'h0;
      lat = 3'h0;
      resetn = 1'b0;
      void'($urandom(32'h9d43a605));
      do_reset();
      for (int i = 0; i < 4; i++)
         acc(32'h0012ffe8 + i, 4'h1 << i);
      acc(32'h0044ffe8, 4'hf);
      acc(32'h0012ffe8, 4'hf);
      repeat (2) acc(32'h0112ffe8, 4'hf);
      acc(32'h0012ffe8, 4'hf);
      // random mix over few tags and indexes
      repeat (80) begin
         a = $urandom & 32'h0103000f;
         acc(a, 4'($urandom));
      end
      do_reset();
      acc(32'h0012ffe8, 4'hf);
      acc(32'h0012ffe8, 4'h3);
      tally_and_finish();
   end
endmodule
bind dmcc_ctrl dmcc_ctrl_monitor u_dmcc_ctrl_monitor (
   .clk(clk),
   .resetn(resetn),
   .cpu_req(cpu_req),
   .cpu_addr(cpu_addr),
   .cpu_ready_reg(cpu_ready_reg),
   .cpu_hit_reg(cpu_hit_reg),
   .mem_req_reg(mem_req_reg),
   .mem_addr_reg(mem_addr_reg),
   .mem_ack(mem_ack)
);

// ---- dv/dmcc_mem_model.sv ----
// Main memory model answering block reads of the cache controller.
// Assumes one request at a time, held until the acknowledge is seen.
`timescale 1ns/1ps
module dmcc_mem_model (
   input wire clk,
   input wire mem_req_reg,
   input wire [31:0] mem_addr_reg,
   input wire [2:0] lat,
   output logic mem_ack = 1'b0,
   output logic [31:0] mem_rdata = 32'h0
);
   int cnt = 0;
   // One word per request after lat cycles; idle data keeps toggling
   always @(negedge clk) begin
      if (mem_req_reg && !mem_ack && cnt >= lat) begin
         mem_ack <= 1'b1;
         mem_rdata <= mem_addr_reg ^ 32'h3c5aa5c3;
         cnt <= 0;
      end else begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
         cnt <= (mem_req_reg && !mem_ack) ? cnt + 1 : 0;
      end
   end
endmodule

// ---- logic/dmcc_ctrl.v ----
// Direct mapped cache controller between a 32-bit processor bus and memory.
// Assumes the processor holds its request until ready and that main
// memory holds nothing back once it pulses its acknowledge.
`timescale 1ns/1ps
`include "dmcc_defines.vh"

module dmcc_ctrl (
   input wire clk,
   input wire resetn,
   input wire cpu_req,
   input wire [31:0] cpu_addr,
   input wire [3:0] cpu_be,
   output reg cpu_ready_reg,
   output reg [31:0] cpu_rdata_reg,
   output reg cpu_hit_reg,
   output reg mem_req_reg,
   output reg [31:0] mem_addr_reg,
   input wire mem_ack,
   input wire [31:0] mem_rdata
);

   reg [`DMCC_ST_W-1:0] state_reg;
   reg [`DMCC_ST_W-1:0] state_next;
   reg [31:0] addr_reg;
   reg [3:0] be_reg;
   reg [31:0] fill_data_reg;
   wire [`DMCC_TAG_W-1:0] st_tag;
   wire st_valid;
   wire [31:0] st_data;
   wire fill_we;
   wire [`DMCC_INDEX_W-1:0] look_index;
   wire cacheable;
   wire hit;
   wire look_hit;

   // Keep only the byte lanes that the processor enabled
   function [31:0] lane_mask;
      input [31:0] word;
      input [3:0] be;
      begin
         lane_mask = word & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      end
   endfunction

   // Index field of a byte address
   function [`DMCC_INDEX_W-1:0] index_of;
      input [31:0] addr;
      begin
         index_of = addr[`DMCC_INDEX_HI:`DMCC_INDEX_LO];
      end
   endfunction

   // Tag field of a byte address
   function [`DMCC_TAG_W-1:0] tag_of;
      input [31:0] addr;
      begin
         tag_of = addr[`DMCC_TAG_HI:`DMCC_TAG_LO];
      end
   endfunction

   // address field split
   // Index comes from the live address when idle, else the held one,
   // so the store read is already done when the lookup state starts
   assign look_index = (state_reg == `DMCC_ST_IDLE) ?
      index_of(cpu_addr) : index_of(addr_reg);

   assign cacheable =
      (addr_reg[`DMCC_REGION_HI:`DMCC_REGION_LO] == `DMCC_CACHED_REGION);

   assign hit = st_valid && (st_tag == tag_of(addr_reg));

   // A cached hit is served at once; anything else goes to memory
   assign look_hit = cacheable && hit;

   // Fill write happens when memory acknowledges a cached miss
   assign fill_we = (state_reg == `DMCC_ST_FILL) && mem_ack;

   // Tag, valid and data store
   dmcc_store u_store (
      .clk(clk),
      .resetn(resetn),
      .rd_index(look_index),
      .wr_en(fill_we),
      .wr_index(index_of(addr_reg)),
      .wr_tag(tag_of(addr_reg)),
      .wr_data(mem_rdata),
      .rd_tag_reg(st_tag),
      .rd_valid_reg(st_valid),
      .rd_data_reg(st_data)
   );

   // Next-state decision
   always @* begin
      state_next = state_reg;
      case (state_reg)
         `DMCC_ST_IDLE: begin
            if (cpu_req) begin
               state_next = `DMCC_ST_LOOK;
            end
         end
         `DMCC_ST_LOOK: begin
            if (!cacheable) begin
               state_next = `DMCC_ST_BYPASS;
            end else if (hit) begin
               state_next = `DMCC_ST_DONE;
            end else begin
               state_next = `DMCC_ST_FILL;
            end
         end
         `DMCC_ST_FILL: begin
            if (mem_ack) begin
               state_next = `DMCC_ST_DELIVER;
            end
         end
         `DMCC_ST_DELIVER: begin
            state_next = `DMCC_ST_DONE;
         end
         `DMCC_ST_BYPASS: begin
            if (mem_ack) begin
               state_next = `DMCC_ST_DONE;
            end
         end
         `DMCC_ST_DONE: begin
            state_next = `DMCC_ST_IDLE;
         end
         default: begin
            state_next = `DMCC_ST_IDLE;
         end
      endcase
   end

   // State register and request capture
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= `DMCC_ST_IDLE;
         addr_reg <= 32'h00000000;
         be_reg <= 4'h0;
      end else begin
         state_reg <= state_next;
         if (state_reg == `DMCC_ST_IDLE && cpu_req) begin
            addr_reg <= cpu_addr;
            be_reg <= cpu_be;
         end
      end
   end

   // Memory request: the same word-aligned address for fills and for bypass reads
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mem_req_reg <= 1'b0;
         mem_addr_reg <= 32'h00000000;
      end else if (state_reg == `DMCC_ST_LOOK && !look_hit) begin
         mem_req_reg <= 1'b1;
         mem_addr_reg <= {addr_reg[31:`DMCC_INDEX_LO], 2'b00};
      end else if (mem_ack) begin
         mem_req_reg <= 1'b0;
      end
   end

   // Fill data held for delivery after the block and tag are stored
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fill_data_reg <= 32'h00000000;
      end else if (fill_we) begin
         fill_data_reg <= mem_rdata;
      end
   end

   // Processor answer: data, hit flag and one-cycle ready
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cpu_ready_reg <= 1'b0;
         cpu_rdata_reg <= 32'h00000000;
         cpu_hit_reg <= 1'b0;
      end else begin
         cpu_ready_reg <= 1'b0;
         case (state_reg)
            `DMCC_ST_LOOK: begin
               if (look_hit) begin
                  cpu_ready_reg <= 1'b1;
                  cpu_hit_reg <= 1'b1;
                  cpu_rdata_reg <= lane_mask(st_data, be_reg);
               end
            end
            `DMCC_ST_DELIVER: begin
               cpu_ready_reg <= 1'b1;
               cpu_hit_reg <= 1'b0;
               cpu_rdata_reg <= lane_mask(fill_data_reg, be_reg);
            end
            `DMCC_ST_BYPASS: begin
               if (mem_ack) begin
                  cpu_ready_reg <= 1'b1;
                  cpu_hit_reg <= 1'b0;
                  cpu_rdata_reg <= lane_mask(mem_rdata, be_reg);
               end
            end
            default: begin
               cpu_ready_reg <= 1'b0;
            end
         endcase
      end
   end

endmodule

// ---- logic/dmcc_defines.vh ----
// Address split, region decode and state codes for the cache controller.
// Included by every design file of the block; holds definitions only.
`ifndef DMCC_DEFINES_VH
`define DMCC_DEFINES_VH

// Address field positions
`define DMCC_REGION_HI 31
`define DMCC_REGION_LO 24
`define DMCC_TAG_HI 23
`define DMCC_TAG_LO 16
`define DMCC_INDEX_HI 15
`define DMCC_INDEX_LO 2
`define DMCC_BYTE_HI 1
`define DMCC_BYTE_LO 0

// Field widths and store depth
`define DMCC_TAG_W 8
`define DMCC_INDEX_W 14
`define DMCC_DEPTH 16384
`define DMCC_REGION_W 8

// Region code that selects the cached memory
`define DMCC_CACHED_REGION 8'h00

// One-hot controller states
`define DMCC_ST_W 6
`define DMCC_ST_IDLE 6'h01
`define DMCC_ST_LOOK 6'h02
`define DMCC_ST_FILL 6'h04
`define DMCC_ST_DELIVER 6'h08
`define DMCC_ST_BYPASS 6'h10
`define DMCC_ST_DONE 6'h20

`endif

// ---- logic/dmcc_store.v ----
// Tag, valid and data store of the direct mapped cache: one entry per index.
// Assumes a single clock; read data appears one clock after the index.
`timescale 1ns/1ps
`include "dmcc_defines.vh"

module dmcc_store (
   input wire clk,
   input wire resetn,
   input wire [`DMCC_INDEX_W-1:0] rd_index,
   input wire wr_en,
   input wire [`DMCC_INDEX_W-1:0] wr_index,
   input wire [`DMCC_TAG_W-1:0] wr_tag,
   input wire [31:0] wr_data,
   output reg [`DMCC_TAG_W-1:0] rd_tag_reg,
   output reg rd_valid_reg,
   output reg [31:0] rd_data_reg
);

   reg [`DMCC_TAG_W-1:0] tag_mem [0:`DMCC_DEPTH-1];
   reg [31:0] data_mem [0:`DMCC_DEPTH-1];
   reg [`DMCC_DEPTH-1:0] valid_reg;

   // valid cleared
   // Valid flags clear on reset and set when a block is filled
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         valid_reg <= {`DMCC_DEPTH{1'b0}};
      end else if (wr_en) begin
         valid_reg[wr_index] <= 1'b1;
      end
   end

   // replace block, tag
   // Block and tag are written together at the fill edge
   always @(posedge clk) begin
      if (wr_en) begin
         tag_mem[wr_index] <= wr_tag;
         data_mem[wr_index] <= wr_data;
      end
   end

   // indexed tag read
   // Registered read of the entry at the looked-up index
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rd_tag_reg <= {`DMCC_TAG_W{1'b0}};
         rd_valid_reg <= 1'b0;
         rd_data_reg <= 32'h00000000;
      end else begin
         rd_tag_reg <= tag_mem[rd_index];
         rd_valid_reg <= valid_reg[rd_index];
         rd_data_reg <= data_mem[rd_index];
      end
   end

endmodule
